/* File: hw/instr_timing_pkg.sv */
// Package for the instruction timing decoder: opcodes, byte and cycle counts.
// Assumes a single clock domain; one instruction cycle is one clock period.
package instr_timing_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CYCLE_TIME_NS = 100;
  localparam int unsigned CYCLE_CLOCKS = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_IRQ_CALL = 4'h3;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] WAIT_RESET = 3'h0;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_JUMP_BIT_SET_AND_CLEAR = 8'h10;
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL = 8'h12;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h32;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JMP_ADPTR = 8'h73;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_D_IMM = 8'h75;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_ORL_C_BIT = 8'h72;
  localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_MOV_D_D = 8'h85;
  localparam logic [7:0] OP_MOV_PTR_IMM = 8'h90;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CODE_PTR = 8'h93;
  localparam logic [7:0] OP_ORL_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_COMPARE_JUMP_A_IMM = 8'hB4;
  localparam logic [7:0] OP_COMPARE_JUMP_A_DIR = 8'hB5;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_XCH_A_DIR = 8'hC5;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [7:0] OP_SETB_BIT = 8'hD2;
  localparam logic [7:0] OP_SETB_C = 8'hD3;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
  localparam logic [7:0] OP_XCHD_R0 = 8'hD6;
  localparam logic [7:0] OP_XCHD_R1 = 8'hD7;
  localparam logic [7:0] OP_XMOV_RD_PTR = 8'hE0;
  localparam logic [7:0] OP_XMOV_RD_R0 = 8'hE2;
  localparam logic [7:0] OP_XMOV_RD_R1 = 8'hE3;
  localparam logic [7:0] OP_MOV_A_DIR = 8'hE5;
  localparam logic [7:0] OP_XMOV_WR_PTR = 8'hF0;
  localparam logic [7:0] OP_XMOV_WR_R0 = 8'hF2;
  localparam logic [7:0] OP_XMOV_WR_R1 = 8'hF3;
  localparam logic [7:0] OP_MOV_DIR_A = 8'hF5;

  // Operand families keyed by the opcode's low five bits or its high nibble
  localparam logic [4:0] FAM_AJMP = 5'h01;
  localparam logic [4:0] FAM_ACALL = 5'h11;
  localparam logic [3:0] HI_MOV_R_IMM = 4'h7;
  localparam logic [3:0] HI_MOV_D_R = 4'h8;
  localparam logic [3:0] HI_MOV_R_D = 4'hA;
  localparam logic [3:0] HI_COMPARE_JUMP_R = 4'hB;
  localparam logic [3:0] HI_XCH = 4'hC;
  localparam logic [3:0] HI_DJNZ_R = 4'hD;
  localparam logic [3:0] HI_MOV_A_R = 4'hE;
  localparam logic [3:0] HI_MOV_R_A = 4'hF;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {ADDR_NONE, ADDR_8, ADDR_16} ext_addr_t;

  typedef struct packed {
    logic known;
    logic [1:0] length;
    logic [3:0] cycles;
    logic ext_move;
    logic ext_write;
    ext_addr_t ext_addr;
    logic bit_clear_on_jump;
  } op_timing_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand1;
    logic [7:0] operand2;
  } instr_bytes_t;

endpackage

/* File: hw/opcode_timing_table.sv */
// Combinational lookup from an opcode to its length and base cycle count.
// Assumes the caller adds external wait states and the interrupt call case.
module opcode_timing_table
  import instr_timing_pkg::*;
(
  // Opcode in
  input wire logic [7:0] opcode_in,
  // Timing out
  output op_timing_t timing_out
);

  function automatic op_timing_t entry(input logic [1:0] len, input logic [3:0] cyc);
    op_timing_t t;
    t = '0;
    t.known = 1'b1;
    t.length = len;
    t.cycles = cyc;
    t.ext_addr = ADDR_NONE;
    return t;
  endfunction

  always_comb begin
    timing_out = '0;
    timing_out.ext_addr = ADDR_NONE;
    if (opcode_in[3]) begin
      // Bank register forms
      case (opcode_in[7:4])
        HI_MOV_A_R, HI_MOV_R_A, HI_XCH: timing_out = entry(LEN_1, CYC_1);
        HI_MOV_R_IMM, HI_MOV_D_R, HI_MOV_R_D: timing_out = entry(LEN_2, CYC_2);
        HI_DJNZ_R: timing_out = entry(LEN_2, CYC_3);
        HI_COMPARE_JUMP_R: timing_out = entry(LEN_3, CYC_4);
        default: timing_out = '0;
      endcase
    end else if (opcode_in[3:1] == 3'h3) begin
      // Register-indirect forms, R0 or R1
      case (opcode_in[7:4])
        HI_MOV_A_R, HI_MOV_R_A, HI_XCH: timing_out = entry(LEN_1, CYC_2);
        HI_MOV_R_IMM, HI_MOV_D_R, HI_MOV_R_D: timing_out = entry(LEN_2, CYC_2);
        HI_COMPARE_JUMP_R: timing_out = entry(LEN_3, CYC_4);
        HI_DJNZ_R: timing_out = entry(LEN_1, CYC_2);
        default: timing_out = '0;
      endcase
    end else if (opcode_in[4:0] == FAM_AJMP || opcode_in[4:0] == FAM_ACALL) begin
      timing_out = entry(LEN_2, CYC_3);
    end else begin
      case (opcode_in)
        OP_NOP, OP_RR, OP_RRC, OP_RLC: timing_out = entry(LEN_1, CYC_1);
        OP_CLR_C, OP_SETB_C, OP_CPL_C: timing_out = entry(LEN_1, CYC_1);
        OP_CLR_BIT, OP_SETB_BIT, OP_CPL_BIT: timing_out = entry(LEN_2, CYC_2);
        OP_ANL_C_BIT, OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT, OP_MOV_C_BIT,
        OP_MOV_BIT_C: timing_out = entry(LEN_2, CYC_2);
        OP_MOV_A_IMM, OP_MOV_A_DIR, OP_MOV_DIR_A, OP_XCH_A_DIR: timing_out = entry(LEN_2, CYC_2);
        OP_MOV_D_D, OP_MOV_D_IMM, OP_MOV_PTR_IMM: timing_out = entry(LEN_3, CYC_3);
        OP_CODE_PTR, OP_CODE_PC: timing_out = entry(LEN_1, CYC_4);
        OP_PUSH, OP_POP: timing_out = entry(LEN_2, CYC_2);
        OP_JMP_ADPTR: timing_out = entry(LEN_1, CYC_3);
        OP_INTERRUPT_RETURN: timing_out = entry(LEN_1, CYC_4);
        OP_SJMP, OP_JC, OP_JNC, OP_JZ, OP_JNZ: timing_out = entry(LEN_2, CYC_3);
        OP_LJMP, OP_LONG_SUBROUTINE_CALL: timing_out = entry(LEN_3, CYC_4);
        OP_JB, OP_JNB: timing_out = entry(LEN_3, CYC_4);
        OP_JUMP_BIT_SET_AND_CLEAR: begin
          timing_out = entry(LEN_3, CYC_4);
          timing_out.bit_clear_on_jump = 1'b1;
        end
        OP_COMPARE_JUMP_A_IMM, OP_COMPARE_JUMP_A_DIR, OP_DJNZ_DIR: timing_out = entry(LEN_3, CYC_4);
        OP_XMOV_RD_R0, OP_XMOV_RD_R1, OP_XMOV_WR_R0, OP_XMOV_WR_R1, OP_XMOV_RD_PTR,
        OP_XMOV_WR_PTR: begin
          timing_out = entry(LEN_1, CYC_4);
          timing_out.ext_move = 1'b1;
          timing_out.ext_write = opcode_in[4];
          timing_out.ext_addr = opcode_in[1] ? ADDR_8 : ADDR_16;
        end
        default: timing_out = '0;
      endcase
    end
  end

endmodule

/* File: hw/cpu_instruction_timing.sv */
// Instruction length and cycle timing sequencer for the single-cycle core.
// Assumes program memory returns the addressed byte in the same cycle and
// that operand bytes arrive in order after the opcode.
//
// Function
// - One instruction cycle is one clock.
// - Rotates through carry and right: one cycle.
// - Accumulator to bank register moves: one cycle.
// - Indirect moves, indirect and direct exchanges, nibble swap: two cycles; bank register exchange: one.
// - Direct or immediate two-byte moves: two cycles.
// - Three-byte moves and pointer load: three cycles.
// - Code memory reads: one byte, four cycles.
// - External moves take four plus wait states.
// - External moves: 8-bit or 16-bit address.
// - Push and pop: two bytes, two cycles.
// - Carry ops one cycle; bit ops two.
// - Carry with bit logic: two cycles.
// - Indirect jump via pointer: three cycles.
// - Interrupt return: one byte, four cycles.
// - Absolute call and jump: three cycles.
// - Short and conditional jumps: three cycles.
// - Long jump and call: four cycles.
// - Interrupt-inserted long call takes three cycles.
// - Bit test jumps: four cycles, clear option.
// - Compare-jump and direct decrement-jump: four cycles.
module cpu_instruction_timing
  import instr_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Program memory byte stream
  input wire logic [7:0] code_byte_in,
  input wire logic code_valid_in,
  // Interrupt call insertion
  input wire logic irq_call_in,
  // Wait states for external moves
  input wire logic [2:0] external_wait_state_count_in,
  // Fetch and status outputs
  output logic fetch_ready_out,
  output logic instr_start_out,
  output logic instr_done_out,
  output logic busy_out,
  output instr_bytes_t instr_out,
  output logic [1:0] instr_length_out,
  output logic [3:0] instr_cycles_out,
  output logic illegal_out,
  output logic ext_move_out,
  output logic ext_write_out,
  output logic ext_addr16_out,
  output logic bit_clear_on_jump_out,
  output logic irq_call_out
);

  // ****************************************
  // Decode of the incoming opcode
  // ****************************************
  typedef enum logic [1:0] {ST_FETCH, ST_OPERAND, ST_EXECUTE} seq_state_t;

  seq_state_t state;
  op_timing_t table_timing;
  logic [1:0] bytes_left;
  logic [3:0] cycles_left;
  logic operand_index;
  logic [3:0] next_total;

  opcode_timing_table u_table (
    .opcode_in(code_byte_in),
    .timing_out(table_timing)
  );

  // Total cycle count of the instruction about to start; the wait count
  // is only looked at on the opcode edge, so later changes never stretch a move
  always_comb begin
    next_total = table_timing.cycles;
    if (irq_call_in) begin
      next_total = CYC_IRQ_CALL;
    end else if (table_timing.ext_move) begin
      next_total = 4'(table_timing.cycles + {1'b0, external_wait_state_count_in});
    end else if (!table_timing.known) begin
      next_total = CYC_1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // The cycle count below moves one step per clock: a cycle is a clock; byte counts step per accepted byte
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_FETCH;
      bytes_left <= 2'h0;
      cycles_left <= 4'h0;
      operand_index <= 1'b0;
    end else begin
      case (state)
        ST_FETCH: begin
          if (irq_call_in) begin
            cycles_left <= CYC_IRQ_CALL - 4'h1;
            bytes_left <= 2'h0;
            state <= ST_EXECUTE;
          end else if (code_valid_in) begin
            cycles_left <= next_total - 4'h1;
            operand_index <= 1'b0;
            bytes_left <= table_timing.known ? table_timing.length - LEN_1 : 2'h0;
            if (table_timing.known && table_timing.length != LEN_1) begin
              state <= ST_OPERAND;
            end else if (next_total != CYC_1) begin
              state <= ST_EXECUTE;
            end
          end
        end
        ST_OPERAND: begin
          if (cycles_left != 4'h0) begin
            cycles_left <= cycles_left - 4'h1;
          end
          if (code_valid_in) begin
            bytes_left <= bytes_left - 2'h1;
            operand_index <= 1'b1;
            if (bytes_left == 2'h1) begin
              state <= (cycles_left > 4'h1) ? ST_EXECUTE : ST_FETCH;
            end
          end
        end
        ST_EXECUTE: begin
          cycles_left <= cycles_left - 4'h1;
          if (cycles_left == 4'h1) begin
            state <= ST_FETCH;
          end
        end
        default: state <= ST_FETCH;
      endcase
    end
  end

  // Operand capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr_out <= '0;
    end else if (state == ST_FETCH && code_valid_in && !irq_call_in) begin
      instr_out <= '{opcode: code_byte_in, operand1: 8'h00, operand2: 8'h00};
    end else if (state == ST_OPERAND && code_valid_in) begin
      if (operand_index) begin
        instr_out.operand2 <= code_byte_in;
      end else begin
        instr_out.operand1 <= code_byte_in;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr_start_out <= 1'b0;
      instr_length_out <= 2'h0;
      instr_cycles_out <= 4'h0;
      illegal_out <= 1'b0;
      ext_move_out <= 1'b0;
      ext_write_out <= 1'b0;
      ext_addr16_out <= 1'b0;
      bit_clear_on_jump_out <= 1'b0;
      irq_call_out <= 1'b0;
    end else begin
      instr_start_out <= 1'b0;
      if (state == ST_FETCH && (code_valid_in || irq_call_in)) begin
        instr_start_out <= 1'b1;
        instr_cycles_out <= next_total;
        irq_call_out <= irq_call_in;
        instr_length_out <= irq_call_in ? LEN_3 : (table_timing.known ? table_timing.length : LEN_1);
        illegal_out <= !irq_call_in && !table_timing.known;
        ext_move_out <= !irq_call_in && table_timing.ext_move;
        ext_write_out <= !irq_call_in && table_timing.ext_write;
        ext_addr16_out <= !irq_call_in && table_timing.ext_addr == ADDR_16;
        bit_clear_on_jump_out <= !irq_call_in && table_timing.bit_clear_on_jump;
      end
    end
  end

  // Completion strobe and fetch gating
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr_done_out <= 1'b0;
      fetch_ready_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      instr_done_out <= 1'b0;
      case (state)
        ST_FETCH: begin
          if ((code_valid_in || irq_call_in) && !irq_call_in && next_total == CYC_1 &&
              (!table_timing.known || table_timing.length == LEN_1)) begin
            instr_done_out <= 1'b1;
            fetch_ready_out <= 1'b1;
            busy_out <= 1'b0;
          end else if (code_valid_in || irq_call_in) begin
            fetch_ready_out <= 1'b0;
            busy_out <= 1'b1;
          end
        end
        ST_OPERAND: begin
          if (code_valid_in && bytes_left == 2'h1) begin
            fetch_ready_out <= 1'b0;
            if (cycles_left <= 4'h1) begin
              instr_done_out <= 1'b1;
              fetch_ready_out <= 1'b1;
              busy_out <= 1'b0;
            end
          end
        end
        ST_EXECUTE: begin
          if (cycles_left == 4'h1) begin
            instr_done_out <= 1'b1;
            fetch_ready_out <= 1'b1;
            busy_out <= 1'b0;
          end
        end
        default: fetch_ready_out <= 1'b1;
      endcase
    end
  end

endmodule

/* File: test/cpu_instruction_timing_chk.sv */
// Timing checker for the instruction sequencer, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
module cpu_instruction_timing_chk
  import instr_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Sequencer inputs
  input wire logic [7:0] code_byte_in,
  input wire logic code_valid_in,
  input wire logic irq_call_in,
  input wire logic [2:0] external_wait_state_count_in,
  // Sequencer outputs
  input wire logic fetch_ready_out,
  input wire logic instr_start_out,
  input wire logic instr_done_out,
  input wire logic busy_out,
  input wire instr_bytes_t instr_out,
  input wire logic [1:0] instr_length_out,
  input wire logic [3:0] instr_cycles_out,
  input wire logic illegal_out,
  input wire logic ext_move_out,
  input wire logic ext_write_out,
  input wire logic ext_addr16_out,
  input wire logic bit_clear_on_jump_out,
  input wire logic irq_call_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ****************************************
  // Assertions
  // ****************************************
  a_start_follows_take: assert property ((code_valid_in || irq_call_in) && fetch_ready_out |=> instr_start_out)
    else $error("no start after an accepted opcode");
  a_no_early_fetch: assert property (!fetch_ready_out |=> !instr_start_out)
    else $error("start without an accepted opcode");
  a_done_frees_fetch: assert property (instr_done_out |-> fetch_ready_out && !busy_out)
    else $error("fetch not ready at completion");
  a_irq_call_three: assert property (irq_call_in && fetch_ready_out |=> irq_call_out && instr_cycles_out == 4'h3
    && !instr_done_out ##1 !instr_done_out ##1 instr_done_out)
    else $error("interrupt call not three cycles");
  a_one_cycle_op: assert property (instr_start_out && instr_cycles_out == 4'h1 |-> instr_done_out)
    else $error("one-cycle op not done at once");
  a_two_cycle_op: assert property (instr_start_out && instr_cycles_out == 4'h2 |->
    !instr_done_out ##1 instr_done_out) else $error("two-cycle op wrong length");
  a_three_cycle_op: assert property (instr_start_out && instr_cycles_out == 4'h3 |->
    !instr_done_out[*2] ##1 instr_done_out) else $error("three-cycle op wrong length");
  a_four_cycle_op: assert property (instr_start_out && instr_cycles_out == 4'h4 |->
    !instr_done_out[*3] ##1 instr_done_out) else $error("four-cycle op wrong length");
  a_wait_states_added: assert property (instr_start_out && ext_move_out |->
    instr_cycles_out == 4'h4 + {1'b0, $past(external_wait_state_count_in)}) else $error("external move cycles wrong");
  a_ext_addr_kind: assert property (instr_start_out && ext_move_out |->
    ext_addr16_out == (instr_out.opcode[1:0] == 2'h0) && ext_write_out == instr_out.opcode[4])
    else $error("external move kind wrong");
  a_bit_clear_jump: assert property (instr_start_out && !irq_call_out |->
    bit_clear_on_jump_out == (instr_out.opcode == OP_JUMP_BIT_SET_AND_CLEAR))
    else $error("bit clear flag wrong");
endmodule

bind cpu_instruction_timing cpu_instruction_timing_chk i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .code_byte_in(code_byte_in), .code_valid_in(code_valid_in), .irq_call_in(irq_call_in),
  .external_wait_state_count_in(external_wait_state_count_in), .fetch_ready_out(fetch_ready_out),
  .instr_start_out(instr_start_out), .instr_done_out(instr_done_out), .busy_out(busy_out),
  .instr_out(instr_out), .instr_length_out(instr_length_out), .instr_cycles_out(instr_cycles_out),
  .illegal_out(illegal_out), .ext_move_out(ext_move_out), .ext_write_out(ext_write_out),
  .ext_addr16_out(ext_addr16_out), .bit_clear_on_jump_out(bit_clear_on_jump_out), .irq_call_out(irq_call_out));

/* File: test/prog_mem_model.sv */
// Program memory model feeding opcodes and operand bytes to the sequencer.
// Assumes the bench loads mem from address 0 while run_in is low.
module prog_mem_model
  import instr_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bench control
  input wire logic run_in,
  input wire logic slow_in,
  input wire logic [9:0] end_in,
  // Sequencer status
  input wire logic fetch_ready_in,
  input wire logic busy_in,
  input wire logic irq_in,
  input wire logic irq_busy_in,
  input wire logic [1:0] length_in,
  // Byte stream
  output logic [7:0] code_byte_out,
  output logic code_valid_out,
  output logic [9:0] pc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:1023];
  logic [1:0] taken;
  logic op_kind;
  logic gap;
  logic due;
  logic offer;

  initial begin
    code_byte_out = 8'h00;
    code_valid_out = 1'b0;
    op_kind = 1'b0;
    gap = 1'b0;
    taken = 2'h0;
  end

  // Opcodes only when fetch is ready; slow mode skips every other cycle
  always @(negedge clk_in) begin
    due = busy_in && !fetch_ready_in && !irq_busy_in && taken < length_in;
    offer = run_in && pc_out < end_in && (due || (fetch_ready_in && !(slow_in && gap)));
    gap <= ~gap;
    op_kind <= !due;
    code_valid_out <= offer;
    // Released bus toggles so a stale byte is never mistaken for data
    code_byte_out <= offer ? mem[pc_out] : ~code_byte_out;
  end

  // An interrupt call consumes no byte, so the opcode is offered again
  always @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      pc_out <= 10'h000;
    end else if (code_valid_out && !(irq_in && op_kind)) begin
      pc_out <= pc_out + 10'h001;
      taken <= op_kind ? 2'h1 : taken + 2'h1;
    end
  end
endmodule

/* File: test/cpu_instruction_timing_tb.sv */
// Self-checking bench for the instruction timing sequencer.
// Assumes the program memory model and the bound timing checker.
module cpu_instruction_timing_tb
  import instr_timing_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic irq; instr_bytes_t b; op_timing_t t;} exp_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic irq_call_in = 1'b0;
  logic [2:0] external_wait_state_count_in = 3'h0;
  logic run_en = 1'b0;
  logic slow = 1'b0;
  logic [9:0] end_addr = 10'h000;
  logic [9:0] pc;
  logic [7:0] code_byte_in;
  logic code_valid_in;
  logic fetch_ready_out, instr_start_out, instr_done_out, busy_out, illegal_out, ext_move_out;
  logic ext_write_out, ext_addr16_out, bit_clear_on_jump_out, irq_call_out;
  logic [1:0] instr_length_out;
  logic [3:0] instr_cycles_out;
  instr_bytes_t instr_out;
  exp_t exp_q[$];
  exp_t cur;
  logic active = 1'b0;
  int cnt = 0;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0000001F;
  logic [9:0] wp = 10'h000;
  logic [2:0] wait_n = 3'h0;
  logic [7:0] dir_ops [$] = '{8'h00, 8'h03, 8'h13, 8'h33, 8'hE8, 8'hFF, 8'hC9, 8'hC3, 8'hD3, 8'hB3, 8'hE6,
    8'hF7, 8'hC6, 8'hD7, 8'hE5, 8'h74, 8'h78, 8'hF5, 8'hA8, 8'h8F, 8'h76, 8'h86, 8'hA7, 8'hC5, 8'hC0, 8'hD0,
    8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92, 8'h85, 8'h75, 8'h90, 8'h93, 8'h83, 8'h32,
    8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3, 8'h73, 8'h01, 8'h11, 8'hE1, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70,
    8'hD8, 8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hB6, 8'hBF, 8'hD5, 8'hA5};

  always #50 clk_in = ~clk_in;

  cpu_instruction_timing i_dut (.clk_in(clk_in), .rst_in(rst_in), .code_byte_in(code_byte_in),
    .code_valid_in(code_valid_in), .irq_call_in(irq_call_in),
    .external_wait_state_count_in(external_wait_state_count_in), .fetch_ready_out(fetch_ready_out),
    .instr_start_out(instr_start_out), .instr_done_out(instr_done_out), .busy_out(busy_out),
    .instr_out(instr_out), .instr_length_out(instr_length_out), .instr_cycles_out(instr_cycles_out),
    .illegal_out(illegal_out), .ext_move_out(ext_move_out), .ext_write_out(ext_write_out),
    .ext_addr16_out(ext_addr16_out), .bit_clear_on_jump_out(bit_clear_on_jump_out), .irq_call_out(irq_call_out));

  prog_mem_model i_prog (.clk_in(clk_in), .rst_in(rst_in), .run_in(run_en), .slow_in(slow), .end_in(end_addr),
    .fetch_ready_in(fetch_ready_out), .busy_in(busy_out), .irq_in(irq_call_in), .irq_busy_in(irq_call_out),
    .length_in(instr_length_out), .code_byte_out(code_byte_in), .code_valid_out(code_valid_in), .pc_out(pc));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic op_timing_t exp_of(input logic [7:0] op, input logic [2:0] n);
    op_timing_t t;
    t = '0;
    t.known = 1'b1;
    case (op) inside
      8'h00, 8'h03, 8'h13, 8'h33, 8'hC3, 8'hD3, 8'hB3, [8'hC8:8'hCF], [8'hE8:8'hEF], [8'hF8:8'hFF]: begin
        {t.length, t.cycles} = 6'h11;
      end
      8'hE6, 8'hE7, 8'hF6, 8'hF7, 8'hC6, 8'hC7, 8'hD6, 8'hD7: {t.length, t.cycles} = 6'h12;
      8'hE5, 8'h74, [8'h78:8'h7F], 8'hF5, [8'hA8:8'hAF], [8'h88:8'h8F], 8'h76, 8'h77, 8'h86, 8'h87, 8'hA6, 8'hA7,
        8'hC5, 8'hC0, 8'hD0, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92: begin
        {t.length, t.cycles} = 6'h22;
      end
      8'h85, 8'h75, 8'h90: {t.length, t.cycles} = 6'h33;
      8'h93, 8'h83, 8'h32: {t.length, t.cycles} = 6'h14;
      8'h73: {t.length, t.cycles} = 6'h13;
      8'b????0001, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, [8'hD8:8'hDF]: {t.length, t.cycles} = 6'h23;
      8'h02, 8'h12, 8'h20, 8'h30, 8'h10, [8'hB4:8'hBF], 8'hD5: {t.length, t.cycles} = 6'h34;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
        {t.length, t.cycles} = {2'h1, 4'h4 + {1'b0, n}};
        t.ext_move = 1'b1;
        t.ext_write = op[4];
        t.ext_addr = (op[1:0] == 2'h0) ? ADDR_16 : ADDR_8;
      end
      default: begin
        t.known = 1'b0;
        {t.length, t.cycles} = 6'h11;
      end
    endcase
    t.bit_clear_on_jump = (op == 8'h10);
    return t;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic add(input logic [7:0] op);
    exp_t e;
    e.irq = 1'b0;
    e.t = exp_of(op, wait_n);
    rng = xorshift(rng);
    e.b = {op, rng[7:0], rng[15:8]};
    i_prog.mem[wp] = op;
    i_prog.mem[wp + 10'h001] = e.b.operand1;
    i_prog.mem[wp + 10'h002] = e.b.operand2;
    wp = wp + 10'(e.t.length);
    exp_q.push_back(e);
  endtask

  task automatic run(input logic s, input logic with_irq);
    int k;
    slow <= s;
    external_wait_state_count_in <= wait_n;
    end_addr <= wp;
    run_en <= 1'b1;
    if (with_irq) begin
      @(negedge clk_in);
      irq_call_in <= 1'b1;
      @(negedge clk_in);
      irq_call_in <= 1'b0;
    end
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (k < 3000 && !(pc == wp && exp_q.size() == 0 && busy_out === 1'b0 && !active));
    check("run finished", 16'(k < 3000), 16'h0001);
    run_en <= 1'b0;
    @(negedge clk_in);
    wp = 10'h000;
  endtask

  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge clk_in) begin
    if (instr_start_out === 1'b1) begin
      cur = exp_q.pop_front();
      active = 1'b1;
      cnt = 0;
      if (!cur.irq) check("opcode", 16'(instr_out.opcode), 16'(cur.b.opcode));
      check("length", 16'(instr_length_out), 16'(cur.t.length));
      check("cycles", 16'(instr_cycles_out), 16'(cur.t.cycles));
      check("flags", {illegal_out, ext_move_out, ext_write_out, ext_addr16_out, bit_clear_on_jump_out,
        irq_call_out}, {!cur.t.known && !cur.irq, cur.t.ext_move, cur.t.ext_write, cur.t.ext_addr == ADDR_16,
        cur.t.bit_clear_on_jump, cur.irq});
    end
    if (active) cnt++;
    if (instr_done_out === 1'b1) begin
      check("done cycle", 16'(cnt), 16'(cur.t.cycles));
      if (!cur.irq && cur.t.length > 2'h1) check("operand1", 16'(instr_out.operand1), 16'(cur.b.operand1));
      if (!cur.irq && cur.t.length == 2'h3) check("operand2", 16'(instr_out.operand2), 16'(cur.b.operand2));
      active = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_t e;
    repeat (10) @(negedge clk_in);
    check("reset outs", {fetch_ready_out, busy_out, instr_start_out, instr_done_out, illegal_out}, 16'h0010);
    rst_in <= 1'b0;
    @(negedge clk_in);
    for (int w = 0; w < 2; w++) begin
      wait_n = w[0] ? 3'h7 : 3'h0;
      foreach (dir_ops[i]) add(dir_ops[i]);
      run(w[0], 1'b0);
    end
    repeat (4) begin
      rng = xorshift(rng);
      wait_n = rng[2:0];
      for (int i = 0; i < 100; i++) begin
        rng = xorshift(rng);
        if (exp_of(rng[7:0], 3'h0).known) add(rng[7:0]);
      end
      run(rng[20], 1'b0);
    end
    // Interrupt call wins over an opcode offered at the same edge
    e = '0;
    e.irq = 1'b1;
    {e.t.length, e.t.cycles} = 6'h33;
    exp_q.push_back(e);
    add(OP_LONG_SUBROUTINE_CALL);
    run(1'b0, 1'b1);
    check("queue empty", 16'(exp_q.size()), 16'h0000);
    stop_test();
  end
endmodule
